// ===== verilog/secure_bus_pkg.sv
// constants shared by the bus encryptor and its request queue
// assumes a byte-wide external sram of up to 128k and a 64-bit key
package secure_bus_pkg;

  localparam int KEY_W = 64;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int VEC_BYTES = 48;
  localparam int VEC_IDX_W = 6;
  localparam int FIFO_DEPTH = 16;

  // queue entry layout: {write, fetch, address, data}
  localparam int ENT_DATA_LSB = 0;
  localparam int ENT_ADDR_LSB = ENT_DATA_LSB + DATA_W;
  localparam int ENT_FETCH_BIT = ENT_ADDR_LSB + ADDR_W;
  localparam int ENT_WE_BIT = ENT_FETCH_BIT + 1;
  localparam int ENT_W = ENT_WE_BIT + 1;

  // memory range chosen while loading
  localparam logic [1:0] RANGE_32K = 2'h0;
  localparam logic [1:0] RANGE_64K = 2'h1;
  localparam logic [1:0] RANGE_128K = 2'h2;
  localparam logic [ADDR_W-1:0] MASK_32K = 17'h07fff;
  localparam logic [ADDR_W-1:0] MASK_64K = 17'h0ffff;
  localparam logic [ADDR_W-1:0] MASK_128K = 17'h1ffff;

  // reset values
  localparam logic [1:0] RANGE_RST = 2'h2;
  localparam logic [KEY_W-1:0] KEY_RST = 64'h0;
  localparam logic [ADDR_W-1:0] LFSR_RST = 17'h00001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // zero fill after an unlock covers the first 32k bytes
  localparam int ZFILL_BYTES = 32768;
  localparam int ZFILL_CNT_W = 15;

  typedef enum logic [0:0] {FILL_IDLE, FILL_RUN} fill_state_e;

endpackage : secure_bus_pkg

// ===== verilog/queue_if.sv
// valid/ready carrier between the encryptor and its request queue
// assumes producer and consumer run on the same clock
`timescale 1ns/10ps
interface queue_if #(parameter int WIDTH = 8);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport queue (
    input push_valid,
    output push_ready,
    input push_data,
    output pop_valid,
    input pop_ready,
    output pop_data
  );

  modport user (
    output push_valid,
    input push_ready,
    output push_data,
    input pop_valid,
    output pop_ready,
    input pop_data
  );
endinterface : queue_if

// ===== verilog/req_queue.sv
// flip-flop fifo holding bus requests in order
// assumes one clock; ready and valid flags are registered
`timescale 1ns/10ps
module req_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // producer and consumer
  queue_if.queue q
);

  localparam int PTR_W = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin
      $error("req_queue depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0] count_ff;
  logic [PTR_W:0] nxt_count;
  logic room_ff;
  logic empty_ff;
  logic do_push;
  logic do_pop;

  assign do_push = q.push_valid && room_ff;
  assign do_pop = q.pop_ready && !empty_ff;
  assign q.push_ready = room_ff;
  assign q.pop_valid = !empty_ff;
  assign q.pop_data = mem_ff[rd_ptr_ff];

  always_comb begin
    nxt_count = count_ff;
    if (do_push && !do_pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (do_pop && !do_push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= q.push_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      room_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      room_ff <= (nxt_count != DEPTH[PTR_W:0]);
      empty_ff <= (nxt_count == '0);
    end
  end

endmodule : req_queue

// ===== verilog/secure_bus_encryptor.sv
// encryption stage between the processor core and the external byte-wide sram
// assumes rst is the backup-domain reset; the lock, key and vector bytes are
// cleared only by it or by an erase, not by ordinary core resets
//
// Overview of operation
// - logical addresses are encrypted before the pins
// - stored bytes are encrypted onto the data pins
// - fetched bytes are decrypted before the core
// - transforms add no cycles to any access
// - distinct transforms, both from one 64-bit key
// - address transform is one-to-one per key
// - address transform spans the configured range
// - data cipher uses key, address and value
// - data cipher is deterministic and reversible
// - encryptors act during loading and execution
// - encryption cannot be turned off
// - loading only while lock is clear
// - clearing the lock erases key and vectors
// - zero fill first 32k after unlock
// - loaded bytes pass through both encryptors
// - new key installed before loading, kept
// - lock set after loading, kept until cleared
// - tampering erases key and protected memory
// - idle bus carries dummy pseudorandom reads outside loading
// - tamper input clears lock like a command
// - vectors held in 48-byte on-chip memory
`timescale 1ns/10ps
module secure_bus_encryptor
  import secure_bus_pkg::*;
#(
  parameter int ZFILL_COUNT = ZFILL_BYTES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // core request port
  input wire logic core_req,
  input wire logic core_we,
  input wire logic core_fetch,
  input wire logic [secure_bus_pkg::ADDR_W-1:0] core_addr,
  input wire logic [secure_bus_pkg::DATA_W-1:0] core_wdata,
  output logic core_ready,
  output logic core_refused,
  output logic core_rvalid,
  output logic [secure_bus_pkg::DATA_W-1:0] core_rdata,
  // loader controls
  input wire logic load_mode,
  input wire logic cmd_lock_set,
  input wire logic cmd_lock_clear,
  input wire logic cmd_key_install,
  input wire logic [secure_bus_pkg::KEY_W-1:0] rng_word,
  input wire logic cmd_range_set,
  input wire logic [1:0] range_sel,
  output logic lock_state,
  output logic erase_busy,
  // tamper pin
  input wire logic tamper_erase_input,
  // external sram
  output logic [secure_bus_pkg::ADDR_W-1:0] sram_addr,
  output logic [secure_bus_pkg::DATA_W-1:0] sram_dout,
  output logic sram_doe,
  input wire logic [secure_bus_pkg::DATA_W-1:0] sram_din,
  output logic sram_ce_n,
  output logic sram_we_n
);
  import secure_bus_pkg::*;

  initial begin
    if (ZFILL_COUNT < 1 || ZFILL_COUNT > ZFILL_BYTES) begin
      $error("ZFILL_COUNT must lie between 1 and 32768");
    end
  end

  localparam logic [ZFILL_CNT_W-1:0] ZFILL_LAST = ZFILL_CNT_W'(ZFILL_COUNT - 1);

  // address scrambler: keyed xor, odd multiply, add, xorshift, all kept
  // inside the range mask so every step permutes that range
  function automatic logic [ADDR_W-1:0] addr_xform(input logic [ADDR_W-1:0] a,
                                                    input logic [KEY_W-1:0] k,
                                                    input logic [ADDR_W-1:0] m);
    logic [ADDR_W-1:0] t;
    logic [ADDR_W-1:0] odd;
    logic [2*ADDR_W-1:0] p;
    t = (a ^ k[16:0]) & m;
    odd = {k[32:17], 1'b1};
    p = t * odd;
    t = p[ADDR_W-1:0] & m;
    t = (t + k[49:33]) & m;
    t = (t ^ (t >> 7)) & m;
    return t;
  endfunction : addr_xform

  function automatic logic [DATA_W-1:0] rotl8(input logic [DATA_W-1:0] x, input logic [2:0] s);
    logic [2*DATA_W-1:0] w;
    w = {x, x} << s;
    return w[2*DATA_W-1:DATA_W];
  endfunction : rotl8

  function automatic logic [DATA_W-1:0] rotr8(input logic [DATA_W-1:0] x, input logic [2:0] s);
    logic [2*DATA_W-1:0] w;
    w = {x, x} >> s;
    return w[DATA_W-1:0];
  endfunction : rotr8

  // data pad, offset and rotation derived from key and logical address
  function automatic logic [DATA_W-1:0] data_pad(input logic [ADDR_W-1:0] a, input logic [KEY_W-1:0] k);
    return k[7:0] ^ a[7:0] ^ a[16:9] ^ k[15:8];
  endfunction : data_pad

  function automatic logic [DATA_W-1:0] data_ofs(input logic [ADDR_W-1:0] a, input logic [KEY_W-1:0] k);
    return k[63:56] + a[15:8] + k[23:16];
  endfunction : data_ofs

  function automatic logic [DATA_W-1:0] data_enc(input logic [DATA_W-1:0] d,
                                                  input logic [ADDR_W-1:0] a,
                                                  input logic [KEY_W-1:0] k);
    logic [DATA_W-1:0] t;
    t = (d ^ data_pad(a, k)) + data_ofs(a, k);
    return rotl8(t, k[58:56] ^ a[2:0]);
  endfunction : data_enc

  function automatic logic [DATA_W-1:0] data_dec(input logic [DATA_W-1:0] e,
                                                  input logic [ADDR_W-1:0] a,
                                                  input logic [KEY_W-1:0] k);
    logic [DATA_W-1:0] t;
    t = rotr8(e, k[58:56] ^ a[2:0]) - data_ofs(a, k);
    return t ^ data_pad(a, k);
  endfunction : data_dec

  function automatic logic [ADDR_W-1:0] range_mask(input logic [1:0] r);
    case (r)
      RANGE_32K: return MASK_32K;
      RANGE_64K: return MASK_64K;
      default: return MASK_128K;
    endcase
  endfunction : range_mask

  // tamper pin synchroniser and agreement filter
  logic tamp1_ff;
  logic tamp2_ff;
  logic tamp3_ff;
  logic tamper_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tamp1_ff <= 1'b0;
      tamp2_ff <= 1'b0;
      tamp3_ff <= 1'b0;
      tamper_ff <= 1'b0;
    end else begin
      tamp1_ff <= tamper_erase_input;
      tamp2_ff <= tamp1_ff;
      tamp3_ff <= tamp2_ff;
      if (tamp2_ff == tamp3_ff) begin
        tamper_ff <= tamp3_ff;
      end
    end
  end

  logic lock_ff;
  logic [KEY_W-1:0] key_ff;
  logic [1:0] range_ff;
  logic [DATA_W-1:0] vec_ff [VEC_BYTES];
  fill_state_e fill_state_ff;
  logic [ZFILL_CNT_W-1:0] fill_cnt_ff;
  logic [ADDR_W-1:0] lfsr_ff;
  logic lock_clr_cmd;
  logic lock_set_cmd;
  logic erase;
  logic filling;
  logic [ADDR_W-1:0] mask;

  assign filling = (fill_state_ff == FILL_RUN);
  assign lock_clr_cmd = load_mode && cmd_lock_clear;
  assign lock_set_cmd = load_mode && cmd_lock_set && !filling;
  assign erase = tamper_ff || lock_clr_cmd;
  assign mask = range_mask(range_ff);

  // lock is backup-domain state; a clear always beats a set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_ff <= 1'b0;
    end else if (erase) begin
      lock_ff <= 1'b0;
    end else if (lock_set_cmd) begin
      lock_ff <= 1'b1;
    end
  end

  // key has no read path; it only feeds the transforms
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      key_ff <= KEY_RST;
    end else if (erase) begin
      key_ff <= KEY_RST;
    end else if (load_mode && cmd_key_install && !lock_ff && !filling) begin
      key_ff <= rng_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      range_ff <= RANGE_RST;
    end else if (load_mode && cmd_range_set && !lock_ff) begin
      range_ff <= range_sel;
    end
  end

  // request acceptance; loader access is blocked while locked
  queue_if #(.WIDTH(ENT_W)) rq ();
  logic blocked;
  logic take;

  assign blocked = load_mode && lock_ff;
  assign rq.push_valid = core_req && !blocked;
  assign rq.push_data = {core_we, core_fetch, core_addr, core_wdata};
  assign take = rq.push_valid && rq.push_ready;
  assign rq.pop_ready = !filling;

  req_queue #(
    .WIDTH(ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .clock(clock),
    .rst(rst),
    .q(rq.queue)
  );

  // vector bytes are written while loading and served to vector fetches
  genvar gi;
  generate
    for (gi = 0; gi < VEC_BYTES; gi++) begin : g_vec
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          vec_ff[gi] <= DATA_ZERO;
        end else if (erase) begin
          vec_ff[gi] <= DATA_ZERO;
        end else if (take && core_we && load_mode && core_addr == ADDR_W'(gi)) begin
          vec_ff[gi] <= core_wdata;
        end
      end
    end
  endgenerate

  // zero fill sequence after any lock clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fill_state_ff <= FILL_IDLE;
      fill_cnt_ff <= '0;
    end else if (erase) begin
      fill_state_ff <= FILL_RUN;
      fill_cnt_ff <= '0;
    end else begin
      case (fill_state_ff)
        FILL_IDLE: begin
          fill_cnt_ff <= '0;
        end
        FILL_RUN: begin
          if (fill_cnt_ff == ZFILL_LAST) begin
            fill_state_ff <= FILL_IDLE;
          end else begin
            fill_cnt_ff <= fill_cnt_ff + 1'b1;
          end
        end
        default: begin
          fill_state_ff <= FILL_IDLE;
        end
      endcase
    end
  end

  // pseudorandom address source for dummy reads
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lfsr_ff <= LFSR_RST;
    end else begin
      lfsr_ff <= {lfsr_ff[ADDR_W-2:0], lfsr_ff[16] ^ lfsr_ff[13]};
    end
  end

  // one bus cycle per clock: fill, then queued request, then dummy read
  logic [ADDR_W-1:0] pop_addr;
  logic [DATA_W-1:0] pop_wdata;
  logic pop_we;
  logic pop_fetch;
  logic pop_vec;
  logic pop_go;
  logic [ADDR_W-1:0] fill_addr;
  logic [ADDR_W-1:0] dummy_addr;

  assign pop_addr = rq.pop_data[ENT_ADDR_LSB +: ADDR_W];
  assign pop_wdata = rq.pop_data[ENT_DATA_LSB +: DATA_W];
  assign pop_we = rq.pop_data[ENT_WE_BIT];
  assign pop_fetch = rq.pop_data[ENT_FETCH_BIT];
  assign pop_vec = pop_fetch && !pop_we && (pop_addr < ADDR_W'(VEC_BYTES));
  assign pop_go = rq.pop_valid && !filling;
  assign fill_addr = {{(ADDR_W-ZFILL_CNT_W){1'b0}}, fill_cnt_ff};
  assign dummy_addr = lfsr_ff & mask;

  logic [ADDR_W-1:0] sram_addr_ff;
  logic [DATA_W-1:0] sram_dout_ff;
  logic sram_doe_ff;
  logic sram_ce_n_ff;
  logic sram_we_n_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sram_addr_ff <= '0;
      sram_dout_ff <= DATA_ZERO;
      sram_doe_ff <= 1'b0;
      sram_ce_n_ff <= 1'b1;
      sram_we_n_ff <= 1'b1;
    end else if (filling) begin
      sram_addr_ff <= addr_xform(fill_addr, key_ff, mask);
      sram_dout_ff <= data_enc(DATA_ZERO, fill_addr, key_ff);
      sram_doe_ff <= 1'b1;
      sram_ce_n_ff <= 1'b0;
      sram_we_n_ff <= 1'b0;
    end else if (pop_go && pop_we) begin
      sram_addr_ff <= addr_xform(pop_addr, key_ff, mask);
      sram_dout_ff <= data_enc(pop_wdata, pop_addr, key_ff);
      sram_doe_ff <= 1'b1;
      sram_ce_n_ff <= 1'b0;
      sram_we_n_ff <= 1'b0;
    end else if (pop_go && !pop_vec) begin
      sram_addr_ff <= addr_xform(pop_addr, key_ff, mask);
      sram_dout_ff <= DATA_ZERO;
      sram_doe_ff <= 1'b0;
      sram_ce_n_ff <= 1'b0;
      sram_we_n_ff <= 1'b1;
    end else if (!load_mode || pop_go) begin
      sram_addr_ff <= dummy_addr;
      sram_dout_ff <= DATA_ZERO;
      sram_doe_ff <= 1'b0;
      sram_ce_n_ff <= 1'b0;
      sram_we_n_ff <= 1'b1;
    end else begin
      sram_dout_ff <= DATA_ZERO;
      sram_doe_ff <= 1'b0;
      sram_ce_n_ff <= 1'b1;
      sram_we_n_ff <= 1'b1;
    end
  end

  // read answer: captured and decrypted at the end of the bus cycle
  logic rd_pend_ff;
  logic rd_vec_ff;
  logic [ADDR_W-1:0] rd_laddr_ff;
  logic [DATA_W-1:0] rd_vdata_ff;
  logic [DATA_W-1:0] core_rdata_ff;
  logic core_rvalid_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_pend_ff <= 1'b0;
      rd_vec_ff <= 1'b0;
      rd_laddr_ff <= '0;
      rd_vdata_ff <= DATA_ZERO;
    end else begin
      rd_pend_ff <= pop_go && !pop_we;
      rd_vec_ff <= pop_vec;
      rd_laddr_ff <= pop_addr;
      rd_vdata_ff <= pop_vec ? vec_ff[pop_addr[VEC_IDX_W-1:0]] : DATA_ZERO;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_rdata_ff <= DATA_ZERO;
      core_rvalid_ff <= 1'b0;
    end else begin
      core_rvalid_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        core_rdata_ff <= rd_vec_ff ? rd_vdata_ff : data_dec(sram_din, rd_laddr_ff, key_ff);
      end
    end
  end

  // status and refusal flags
  logic core_refused_ff;
  logic erase_busy_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_refused_ff <= 1'b0;
      erase_busy_ff <= 1'b0;
    end else begin
      core_refused_ff <= core_req && blocked;
      erase_busy_ff <= erase || (filling && fill_cnt_ff != ZFILL_LAST);
    end
  end

  assign core_ready = rq.push_ready;
  assign core_refused = core_refused_ff;
  assign core_rvalid = core_rvalid_ff;
  assign core_rdata = core_rdata_ff;
  assign lock_state = lock_ff;
  assign erase_busy = erase_busy_ff;
  assign sram_addr = sram_addr_ff;
  assign sram_dout = sram_dout_ff;
  assign sram_doe = sram_doe_ff;
  assign sram_ce_n = sram_ce_n_ff;
  assign sram_we_n = sram_we_n_ff;

endmodule : secure_bus_encryptor

// ===== test/secure_bus_asserts.sv
// assertions on the encryptor's core, loader and sram ports
// assumes one clock and the asynchronous active-high rst
`timescale 1ns/10ps
module secure_bus_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // core and loader
  input wire logic core_req,
  input wire logic core_we,
  input wire logic core_ready,
  input wire logic core_refused,
  input wire logic core_rvalid,
  input wire logic load_mode,
  input wire logic cmd_lock_set,
  input wire logic cmd_lock_clear,
  input wire logic lock_state,
  input wire logic erase_busy,
  input wire logic tamper_erase_input,
  // external sram
  input wire logic sram_doe,
  input wire logic sram_ce_n,
  input wire logic sram_we_n
);
  logic [1:0] quiet_ff;
  logic [5:0] tamp_ff;
  logic halted;
  logic take;
  assign halted = load_mode & lock_state;
  assign take = core_req & core_ready & ~halted;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // cycles since the last accepted request or fill, saturating at 3
  always_ff @(posedge clock or posedge rst) begin
    if (rst) quiet_ff <= 2'h0;
    else if (take | erase_busy) quiet_ff <= 2'h0;
    else if (quiet_ff != 2'h3) quiet_ff <= quiet_ff + 2'h1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) tamp_ff <= 6'h0;
    else tamp_ff <= {tamp_ff[4:0], tamper_erase_input};
  end
  chk_read_latency: assert property (
    take && !core_we && quiet_ff == 2'h3 |=> !core_rvalid ##1 !core_rvalid ##1 core_rvalid)
    else $error("read answer not three cycles after request");
  chk_write_cycle: assert property (
    take && core_we && quiet_ff == 2'h3 |-> ##2 (!sram_ce_n && !sram_we_n && sram_doe))
    else $error("write bus cycle not two cycles after request");
  chk_refuse_when: assert property (core_req && halted |=> core_refused)
    else $error("locked load request not refused");
  chk_refuse_cause: assert property (core_refused |-> $past(core_req && halted))
    else $error("refusal without locked load request");
  chk_clear_erases: assert property (
    load_mode && cmd_lock_clear |=> !lock_state && erase_busy)
    else $error("lock clear did not start erase");
  chk_lock_sets: assert property (
    load_mode && cmd_lock_set && !cmd_lock_clear && !erase_busy && tamp_ff == 6'h0 |=> lock_state)
    else $error("lock set command ignored");
  chk_lock_holds: assert property (
    lock_state && !(load_mode && cmd_lock_clear) && tamp_ff == 6'h0 && !tamper_erase_input |=> lock_state)
    else $error("lock dropped without clear or tamper");
  chk_fill_writes: assert property (
    erase_busy && $past(erase_busy, 2) |-> !sram_ce_n && !sram_we_n)
    else $error("zero fill cycle is not a write");
  chk_doe_write: assert property (sram_doe |-> !sram_ce_n && !sram_we_n)
    else $error("data pins driven outside a write");
  chk_idle_dummy: assert property (
    quiet_ff == 2'h3 && !load_mode && !$past(load_mode) && !$past(load_mode, 2) |-> !sram_ce_n && sram_we_n)
    else $error("idle bus without dummy read");
  cov_read: cover property (take && !core_we);
  cov_refuse: cover property (core_refused);
  cov_fill: cover property ($rose(erase_busy));
endmodule : secure_bus_asserts

// ===== test/sram_model.sv
// behavioural byte-wide sram on the encryptor's external bus
// assumes one clock; reads combinational, writes at the rising edge
`timescale 1ns/10ps
module sram_model
  import secure_bus_pkg::*;
(
  // clock
  input wire logic clock,
  // bus from the encryptor
  input wire logic [secure_bus_pkg::ADDR_W-1:0] sram_addr,
  input wire logic [secure_bus_pkg::DATA_W-1:0] sram_dout,
  input wire logic sram_doe,
  input wire logic sram_ce_n,
  input wire logic sram_we_n,
  output logic [secure_bus_pkg::DATA_W-1:0] sram_din
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last_ff;
  logic rd;
  assign rd = !sram_ce_n && sram_we_n;
  // unselected: inverse of the previous cycle's byte; two idle cycles in a row return a stale copy
  assign sram_din = rd ? mem[sram_addr] : ~last_ff;
  initial begin
    last_ff = 8'h00;
    for (int i = 0; i < 2**ADDR_W; i++) mem[i] = 8'(i) ^ 8'ha5;
  end
  always @(posedge clock) begin
    if (!sram_ce_n && !sram_we_n && sram_doe) mem[sram_addr] <= sram_dout;
    last_ff <= sram_din;
  end
endmodule : sram_model

// ===== test/testbench.sv
// self-checking bench for the secure bus encryptor and its sram
// assumes sram_model on the external bus; zero fill shortened to 32 bytes
`timescale 1ns/10ps
module testbench;
  import secure_bus_pkg::*;
  localparam int ZF = 32;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic core_req = 1'b0;
  logic core_we = 1'b0;
  logic core_fetch = 1'b0;
  logic [ADDR_W-1:0] core_addr = 17'h0;
  logic [DATA_W-1:0] core_wdata = 8'h0;
  logic load_mode = 1'b0;
  logic cmd_lock_set = 1'b0;
  logic cmd_lock_clear = 1'b0;
  logic cmd_key_install = 1'b0;
  logic cmd_range_set = 1'b0;
  logic [KEY_W-1:0] rng_word = 64'h0123456789abcdef;
  logic [1:0] range_sel = RANGE_32K;
  logic tamper_erase_input = 1'b0;
  logic core_ready, core_refused, core_rvalid, lock_state, erase_busy, sram_doe, sram_ce_n, sram_we_n;
  logic [DATA_W-1:0] core_rdata, sram_dout, sram_din;
  logic [ADDR_W-1:0] sram_addr;
  int error_cnt = 0;
  int comparisons = 0;
  logic [16:0] wa[$];
  logic [16:0] wd[$];
  always #50 clock = ~clock;

  secure_bus_encryptor #(.ZFILL_COUNT(ZF)) dut_u (
    .clock, .rst, .core_req, .core_we, .core_fetch, .core_addr, .core_wdata, .core_ready, .core_refused,
    .core_rvalid, .core_rdata, .load_mode, .cmd_lock_set, .cmd_lock_clear, .cmd_key_install, .rng_word,
    .cmd_range_set, .range_sel, .lock_state, .erase_busy, .tamper_erase_input, .sram_addr, .sram_dout,
    .sram_doe, .sram_din, .sram_ce_n, .sram_we_n
  );
  sram_model mem_u (.clock, .sram_addr, .sram_dout, .sram_doe, .sram_ce_n, .sram_we_n, .sram_din);

  // record every write cycle seen on the external bus
  always @(posedge clock) begin
    if (!rst && !sram_ce_n && !sram_we_n) begin
      wa.push_back(sram_addr);
      wd.push_back({9'h0, sram_dout});
    end
  end

  task automatic end_sim;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  task automatic give_up(input string nm);
    error_cnt++;
    $display("unexpected %s: expected done seen timeout", nm);
    end_sim();
  endtask : give_up

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic int uniq(input logic [16:0] q[$]);
    logic [16:0] s[$];
    s = q.unique();
    return s.size();
  endfunction : uniq

  // request held until an edge with ready high takes it; core_req left up
  task automatic req(input logic we, input logic fe, input logic [16:0] a, input logic [7:0] d);
    int n;
    core_req <= 1'b1;
    core_we <= we;
    core_fetch <= fe;
    core_addr <= a;
    core_wdata <= d;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n == 50) give_up("ready");
    end while (!core_ready);
    @(posedge clock);
  endtask : req

  task automatic rd(input logic fe, input logic [16:0] a, input logic [7:0] exp, input string nm);
    int n;
    req(1'b0, fe, a, 8'h00);
    core_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n == 40) give_up("read answer");
    end while (!core_rvalid);
    check(nm, core_rdata, exp);
    @(posedge clock);
  endtask : rd

  // c = {lock set, lock clear, key install, range set}
  task automatic cmd(input logic [3:0] c);
    cmd_lock_set <= c[3];
    cmd_lock_clear <= c[2];
    cmd_key_install <= c[1];
    cmd_range_set <= c[0];
    @(posedge clock);
    cmd_lock_set <= 1'b0;
    cmd_lock_clear <= 1'b0;
    cmd_key_install <= 1'b0;
    cmd_range_set <= 1'b0;
    @(posedge clock);
  endtask : cmd

  task automatic fill_wait;
    int n;
    for (n = 0; !erase_busy; n++) begin
      if (n == 20) give_up("fill start");
      @(negedge clock);
    end
    for (n = 0; erase_busy; n++) begin
      if (n == 400) give_up("fill end");
      @(negedge clock);
    end
    repeat (4) @(posedge clock);
  endtask : fill_wait

  task automatic s_boot;
    int n;
    n = 0;
    repeat (8) begin
      @(negedge clock);
      if (!sram_ce_n && sram_we_n) n++;
    end
    check("dummy reads", n, 8);
    @(posedge clock);
  endtask : s_boot

  task automatic s_load;
    int nseq;
    logic hi;
    nseq = 0;
    hi = 1'b0;
    load_mode <= 1'b1;
    wa.delete();
    cmd(4'h4);
    fill_wait();
    check("fill count", wa.size(), ZF);
    check("fill spread", uniq(wa), ZF);
    check("lock after clear", lock_state, 1'b0);
    cmd(4'h1);
    cmd(4'h2);
    wa.delete();
    wd.delete();
    for (int i = 0; i < 8; i++) begin
      req(1'b1, 1'b0, 17'h100 + 17'(i), 8'h5a);
    end
    req(1'b1, 1'b0, 17'h2, 8'hc3);
    core_req <= 1'b0;
    repeat (6) @(posedge clock);
    for (int i = 1; i < 8; i++) begin
      if (wa[i] == wa[i-1] + 17'h1) nseq++;
    end
    foreach (wa[i]) hi |= |wa[i][16:15];
    check("load writes", uniq(wa), 9);
    check("sequential spots", nseq < 7, 1'b1);
    check("cipher spread", uniq(wd) > 1, 1'b1);
    check("range top bits", hi, 1'b0);
    cmd(4'h8);
    check("lock after set", lock_state, 1'b1);
    load_mode <= 1'b0;
    @(posedge clock);
  endtask : s_load

  task automatic s_refuse;
    int n;
    n = 0;
    load_mode <= 1'b1;
    wa.delete();
    req(1'b1, 1'b0, 17'h100, 8'h00);
    core_req <= 1'b0;
    repeat (4) begin
      @(negedge clock);
      if (core_refused) n++;
    end
    check("refused pulses", n, 1);
    check("locked writes", wa.size(), 0);
    @(posedge clock);
    load_mode <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : s_refuse

  task automatic s_exec;
    for (int i = 0; i < 8; i++) begin
      rd(1'b0, 17'h100 + 17'(i), 8'h5a, "readback");
    end
    rd(1'b1, 17'h101, 8'h5a, "fetch");
    rd(1'b1, 17'h2, 8'hc3, "vector fetch");
    req(1'b1, 1'b0, 17'h200, 8'h77);
    rd(1'b0, 17'h200, 8'h77, "write then read");
  endtask : s_exec

  task automatic s_tamper;
    wa.delete();
    tamper_erase_input <= 1'b1;
    repeat (8) @(posedge clock);
    tamper_erase_input <= 1'b0;
    fill_wait();
    check("lock after tamper", lock_state, 1'b0);
    check("tamper fill", wa.size() >= ZF, 1'b1);
    rd(1'b1, 17'h2, 8'h00, "vector erased");
  endtask : s_tamper

  // zero fill stalls the queue so it fills up, then drains
  task automatic s_queue;
    int n;
    load_mode <= 1'b1;
    cmd(4'h4);
    core_req <= 1'b1;
    core_we <= 1'b1;
    core_fetch <= 1'b0;
    for (n = 0; n < 40; n++) begin
      core_addr <= 17'h300 + 17'(n);
      core_wdata <= 8'(n);
      @(negedge clock);
      if (!core_ready) break;
      @(posedge clock);
    end
    check("queue depth", n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1, 1'b1);
    for (int k = 0; !core_ready; k++) begin
      if (k == 100) give_up("queue drain");
      @(negedge clock);
    end
    @(posedge clock);
    core_req <= 1'b0;
    repeat (60) @(posedge clock);
    rd(1'b0, 17'h300, 8'h00, "queue head");
    rd(1'b0, 17'h300 + 17'(n), 8'(n), "queue tail");
  endtask : s_queue

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    s_boot();
    s_load();
    s_refuse();
    s_exec();
    s_tamper();
    s_queue();
    end_sim();
  end
endmodule : testbench

bind secure_bus_encryptor secure_bus_asserts chk_u (
  .clock, .rst, .core_req, .core_we, .core_ready, .core_refused, .core_rvalid, .load_mode, .cmd_lock_set,
  .cmd_lock_clear, .lock_state, .erase_busy, .tamper_erase_input, .sram_doe, .sram_ce_n, .sram_we_n
);
